//--- rtl/prot_resp_map.svh
// constants for the protection response block: widths, fields, reset values, timing
`ifndef PROT_RESP_MAP_SVH
`define PROT_RESP_MAP_SVH

// protection response control register is reached on a dedicated port, index 0 only
`define PRC_CTRL_WIDTH      8
`define PRC_CTRL_RESET      8'h43

// field positions inside the control register
`define PRC_TRK_DET_EN_BIT  7
`define PRC_PV_DET_EN_BIT   6
`define PRC_TRK_LATCH_BIT   5
`define PRC_OT_LATCH_BIT    4
`define PRC_OC_LATCH_BIT    3
`define PRC_UV_LATCH_BIT    2
`define PRC_OV_LATCH_BIT    1
`define PRC_PV_LATCH_BIT    0

// fault vector layout matches the latch select bits 5..0
`define PRC_NUM_FAULTS      6
`define PRC_FLT_TRK         5
`define PRC_FLT_OT          4
`define PRC_FLT_OC          3
`define PRC_FLT_UV          2
`define PRC_FLT_OV          1
`define PRC_FLT_PV          0

// fault flags are active low: 1 means no fault recorded
`define PRC_FLAG_RESET      6'h3f

// retry / re-enable period
`define PRC_RETRY_TIME_MS   130
`define PRC_CLK_MHZ         200
`define PRC_TIMER_WIDTH     32

`endif

//--- rtl/prot_resp_pkg.sv
// types for the protection response block
package prot_resp_pkg;

	typedef struct packed {
		logic track_fault_detect_en;
		logic phase_volt_err_detect_en;
		logic track_fault_latch_sel;
		logic overtemp_latch_sel;
		logic overcurrent_latch_sel;
		logic undervolt_latch_sel;
		logic overvolt_latch_sel;
		logic phase_volt_latch_sel;
	} ctrl_t;

	// bit order: track, overtemp, overcurrent, undervolt, overvolt, phase volt
	typedef logic [5:0] fault_vec_t;

	typedef enum logic [3:0] {
		ST_OFF     = 4'b0001,
		ST_RUN     = 4'b0010,
		ST_RETRY   = 4'b0100,
		ST_LATCHED = 4'b1000
	} state_t;

endpackage

//--- rtl/protection_response_config.sv
// protection response control: fault qualification, latching or retrying shutdown, fault flags
//
// Behaviour
// RULE_01: control bit 1 set makes overvoltage response latching, clear makes it retry.
// RULE_02: control bit 5 set makes tracking fault response latching, clear makes it retry.
// RULE_03: non-latching trip retries start-up every 130ms until the cause has gone.
// RULE_04: every automatic restart issues a normal ramp start using sequencing and tracking.
// RULE_05: latching trip turns the output off and keeps it off, no retry.
// RULE_06: latched-off restart needs 130ms elapsed, cause gone, and its fault flag cleared.
// RULE_07: turn-on command recycled or input supply recycled also releases a latched-off state.
// RULE_08: bits 7,6 enable tracking and phase detection; bits 4,3,2,0 select latching.
// RULE_09: a fault that turns the output off drives its fault flag to 0.
// RULE_10: non-latching overtemperature restarts once temperature falls below the warning level.
`timescale 1ns/10ps
`default_nettype none
`include "prot_resp_map.svh"

module protection_response_config #(
	parameter int unsigned RETRY_CYCLES = `PRC_RETRY_TIME_MS * 1000 * `PRC_CLK_MHZ
) (
	input  wire logic                         i_mclk,           // controller clock, 200 MHz
	input  wire logic                         i_rst_n,          // power-on reset, async, active low
	input  wire logic                         i_ce,             // clock enable, freezes all state when low
	input  wire logic                         i_ctrl_wr_en,     // write strobe for the control register
	input  wire logic [`PRC_CTRL_WIDTH-1:0]   i_ctrl_wr_data,   // control register write data
	input  wire logic [`PRC_NUM_FAULTS-1:0]   i_flag_clear,     // host clears fault flags (returns them to 1)
	input  wire prot_resp_pkg::fault_vec_t    i_fault_cond,     // fault conditions present, active high
	input  wire logic                         i_ot_below_warn,  // controller temperature below warning level
	input  wire logic                         i_turn_on,        // turn-on command level
	input  wire logic                         i_vin_ok,         // input supply present
	output var  prot_resp_pkg::ctrl_t         o_ctrl,           // control register contents
	output var  prot_resp_pkg::fault_vec_t    o_fault_flags,    // fault flags, active low
	output var  prot_resp_pkg::fault_vec_t    o_trip_cause,     // faults that caused the last shutdown
	output var  logic                         o_output_en,      // output stage enabled
	output var  logic                         o_ramp_start,     // one-cycle pulse: start a regular ramp-up
	output var  logic                         o_retrying,       // off, waiting to retry
	output var  logic                         o_latched_off     // off, latched
);

	prot_resp_pkg::state_t     state_reg;
	prot_resp_pkg::state_t     state_next;
	prot_resp_pkg::fault_vec_t enable_mask;
	prot_resp_pkg::fault_vec_t tripped;
	prot_resp_pkg::fault_vec_t flag_reg;
	logic                      trip;
	logic                      trip_latching;
	logic                      cause_present;
	logic                      flags_cleared;
	logic                      ot_only;
	logic                      timer_start;
	logic                      timer_done;
	logic                      elapsed_reg;
	logic                      power_ok;
	logic                      restart;

	// only tracking and phase voltage detection can be switched off
	assign enable_mask = {o_ctrl.track_fault_detect_en, 4'hf, o_ctrl.phase_volt_err_detect_en};  // RULE_08
	assign tripped       = i_fault_cond & enable_mask;
	assign trip          = state_reg == prot_resp_pkg::ST_RUN && |tripped;
	// bits 5..0 of the control register line up with the fault vector
	assign trip_latching = |(tripped & o_ctrl[5:0]);  // RULE_01 RULE_02 RULE_08
	assign cause_present = |(i_fault_cond & o_trip_cause);
	assign flags_cleared = &(flag_reg | ~o_trip_cause);
	assign ot_only       = o_trip_cause == prot_resp_pkg::fault_vec_t'(1 << `PRC_FLT_OT);
	assign power_ok      = i_turn_on && i_vin_ok;

	always_comb begin
		state_next  = state_reg;
		timer_start = 1'b0;
		restart     = 1'b0;
		unique case (state_reg)
			prot_resp_pkg::ST_OFF: begin
				if (power_ok) begin
					state_next = prot_resp_pkg::ST_RUN;
					restart    = 1'b1;
				end
			end
			prot_resp_pkg::ST_RUN: begin
				if (trip) begin
					timer_start = 1'b1;
					// a latching fault among several wins, so a mixed trip never retries
					if (trip_latching) begin
						state_next = prot_resp_pkg::ST_LATCHED;  // RULE_05
					end else begin
						state_next = prot_resp_pkg::ST_RETRY;
					end
				end
			end
			prot_resp_pkg::ST_RETRY: begin
				if (ot_only && i_ot_below_warn && !cause_present) begin
					state_next = prot_resp_pkg::ST_RUN;  // RULE_10
					restart    = 1'b1;
				end else if (timer_done) begin
					if (cause_present) begin
						timer_start = 1'b1;  // RULE_03
					end else begin
						state_next = prot_resp_pkg::ST_RUN;  // RULE_03
						restart    = 1'b1;  // RULE_04
					end
				end
			end
			prot_resp_pkg::ST_LATCHED: begin
				if (elapsed_reg && !cause_present && flags_cleared) begin
					state_next = prot_resp_pkg::ST_RUN;  // RULE_06
					restart    = 1'b1;
				end
			end
		endcase
		// dropping turn-on or the input supply discards any latch; rising again restarts from off
		if (!power_ok) begin
			state_next  = prot_resp_pkg::ST_OFF;  // RULE_07
			timer_start = 1'b0;
			restart     = 1'b0;
		end
	end

	// one timer serves retry and latch hold-off; only one of them can be pending at a time
	retry_timer #(
		.WIDTH  (`PRC_TIMER_WIDTH),
		.CYCLES (RETRY_CYCLES)
	) u_retry_timer (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_start (timer_start),
		.o_done  (timer_done)
	);

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= prot_resp_pkg::ST_OFF;
		end else if (i_ce) begin
			state_reg <= state_next;
		end
	end

	// status outputs decode the next state so they change on the same edge as state_reg
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_output_en <= 1'b0;
		end else if (i_ce) begin
			o_output_en <= state_next == prot_resp_pkg::ST_RUN;
		end
	end

	// one pulse per entry to run: downstream sequencing must start a fresh ramp every time
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ramp_start <= 1'b0;
		end else if (i_ce) begin
			o_ramp_start <= restart;  // RULE_04
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_retrying <= 1'b0;
		end else if (i_ce) begin
			o_retrying <= state_next == prot_resp_pkg::ST_RETRY;  // RULE_03
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_latched_off <= 1'b0;
		end else if (i_ce) begin
			o_latched_off <= state_next == prot_resp_pkg::ST_LATCHED;  // RULE_05
		end
	end

	// the latched state may only be restarted into run once a full period has passed since the trip
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			elapsed_reg <= 1'b0;
		end else if (i_ce) begin
			if (timer_start) begin
				elapsed_reg <= 1'b0;
			end else if (timer_done) begin
				elapsed_reg <= 1'b1;  // RULE_06
			end
		end
	end

	// kept until the next trip so the host can still tell why the output went off
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_trip_cause <= '0;
		end else if (i_ce) begin
			if (trip) begin
				o_trip_cause <= tripped;
			end
		end
	end

	// no read path: the register contents are always visible on o_ctrl
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ctrl <= prot_resp_pkg::ctrl_t'(`PRC_CTRL_RESET);
		end else if (i_ce) begin
			if (i_ctrl_wr_en) begin
				o_ctrl <= prot_resp_pkg::ctrl_t'(i_ctrl_wr_data);
			end
		end
	end

	// a trip in the same cycle as a host clear keeps the flag at 0
	for (genvar g = 0; g < `PRC_NUM_FAULTS; g++) begin : g_flag
		always_ff @(posedge i_mclk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				flag_reg[g] <= 1'(`PRC_FLAG_RESET >> g);
			end else if (i_ce) begin
				if (trip && tripped[g]) begin
					flag_reg[g] <= 1'b0;  // RULE_09
				end else if (i_flag_clear[g]) begin
					flag_reg[g] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fault_flags <= `PRC_FLAG_RESET;
		end else if (i_ce) begin
			o_fault_flags <= flag_reg;
		end
	end

endmodule

`default_nettype wire

//--- rtl/retry_timer.sv
// one-shot period timer: restarts on i_start, raises o_done for one cycle at expiry
`timescale 1ns/10ps
`default_nettype none

module retry_timer #(
	parameter int unsigned WIDTH  = 32,
	parameter int unsigned CYCLES = 26000000
) (
	input  wire logic i_mclk,   // controller clock
	input  wire logic i_rst_n,  // async reset, active low
	input  wire logic i_ce,     // clock enable
	input  wire logic i_start,  // restart the period
	output var  logic o_done    // one-cycle pulse when the period has elapsed
);

	logic [WIDTH-1:0] count_reg;
	logic             run_reg;

	localparam logic [WIDTH-1:0] LAST = WIDTH'(CYCLES - 1);

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_reg <= '0;
			run_reg   <= 1'b0;
			o_done    <= 1'b0;
		end else if (i_ce) begin
			o_done <= 1'b0;
			if (i_start) begin
				count_reg <= '0;
				run_reg   <= 1'b1;
			end else if (run_reg) begin
				if (count_reg == LAST) begin
					run_reg <= 1'b0;
					o_done  <= 1'b1;
				end else begin
					count_reg <= count_reg + WIDTH'(1);
				end
			end
		end
	end

endmodule

`default_nettype wire

//--- tb/host_model.sv
// host model: clears set fault flags and recycles the turn-on command on request
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input  wire logic                      i_mclk,       // clock
	input  wire logic                      i_clr_req,    // clear set flags
	input  wire logic                      i_recycle,    // drop turn-on
	input  wire prot_resp_pkg::fault_vec_t i_flags,      // flags, low active
	output var  prot_resp_pkg::fault_vec_t o_flag_clear, // clear strobes
	output var  logic                      o_turn_on     // turn-on command
);
	initial begin
		o_flag_clear = 6'h00;
		o_turn_on = 1'h1;
	end
	always @(negedge i_mclk) begin
		o_flag_clear <= i_clr_req ? ~i_flags : 6'h00;
		o_turn_on <= !i_recycle;
	end
endmodule
`default_nettype wire

//--- tb/prot_resp_asserts.sv
// assertion checker for the protection response block
`timescale 1ns/10ps
`default_nettype none
module prot_resp_asserts #(
	parameter int unsigned RETRY_CYCLES = 20
) (
	input wire logic                      i_mclk,          // clock
	input wire logic                      i_rst_n,         // reset
	input wire logic                      i_ce,            // enable
	input wire logic                      i_ctrl_wr_en,    // write
	input wire logic [7:0]                i_ctrl_wr_data,  // data
	input wire prot_resp_pkg::fault_vec_t i_fault_cond,    // faults
	input wire logic                      i_ot_below_warn, // cool
	input wire logic                      i_turn_on,       // on cmd
	input wire logic                      i_vin_ok,        // supply
	input wire prot_resp_pkg::ctrl_t      o_ctrl,          // ctrl
	input wire prot_resp_pkg::fault_vec_t o_fault_flags,   // flags
	input wire prot_resp_pkg::fault_vec_t o_trip_cause,    // cause
	input wire logic                      o_output_en,     // on
	input wire logic                      o_ramp_start,    // ramp
	input wire logic                      o_retrying,      // retry
	input wire logic                      o_latched_off    // latched
);
	int unsigned wait_cnt;
	wire logic       on_ok = i_turn_on && i_vin_ok && i_ce;
	wire logic [5:0] tripv = i_fault_cond & {o_ctrl[7], 4'hf, o_ctrl[6]};
	// enabled cycles spent waiting, so a frozen clock enable cannot fake the period
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n)
			wait_cnt <= 0;
		else if (!o_retrying && !o_latched_off)
			wait_cnt <= 0;
		else if (i_ce)
			wait_cnt <= wait_cnt + 1;
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	AST_CTRL_WR: assert property (i_ce && i_ctrl_wr_en |=> o_ctrl == $past(i_ctrl_wr_data))
		else $error("control write not taken");
	AST_TRIP: assert property (o_output_en && on_ok && tripv != 0 |=> !o_output_en)
		else $error("enabled fault did not stop output");
	AST_LATCH_SEL: assert property (o_output_en && on_ok && (tripv & o_ctrl[5:0]) != 0 |=> o_latched_off)
		else $error("latching fault did not latch");
	AST_NONLATCH: assert property (o_output_en && on_ok && tripv != 0 && (tripv & o_ctrl[5:0]) == 0 |=> o_retrying)
		else $error("non-latching fault did not retry");
	AST_FLAG: assert property ($rose(o_retrying || o_latched_off) && i_ce |=> (o_fault_flags & o_trip_cause) == 6'h00)
		else $error("fault flag not driven low");
	AST_RAMP: assert property ($rose(o_output_en) |-> o_ramp_start)
		else $error("restart without ramp start");
	AST_RETRY_WAIT: assert property ($rose(o_output_en) && $past(o_retrying) && $past(o_trip_cause) != 6'h10
		|-> $past(wait_cnt) >= RETRY_CYCLES) else $error("retry before period elapsed");
	AST_LATCH_WAIT: assert property ($rose(o_output_en) && $past(o_latched_off)
		|-> $past(wait_cnt) >= RETRY_CYCLES) else $error("latch released before period elapsed");
	AST_OT_FAST: assert property (o_retrying && o_trip_cause == 6'h10 && i_ot_below_warn && !i_fault_cond[4]
		&& on_ok |=> o_output_en) else $error("cooled converter did not restart");
	AST_LATCH_HOLD: assert property (o_latched_off && on_ok && (i_fault_cond & o_trip_cause) != 0 |=> o_latched_off)
		else $error("latch released with cause present");
	AST_OFF: assert property ((!i_turn_on || !i_vin_ok) && i_ce |=> !o_output_en && !o_retrying && !o_latched_off)
		else $error("turn-on or supply drop not obeyed");
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the protection response block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int unsigned RC = 20;
	logic                      i_mclk, i_rst_n, i_ce, i_ctrl_wr_en, i_ot_below_warn, i_vin_ok, i_turn_on;
	logic                      o_output_en, o_ramp_start, o_retrying, o_latched_off, clr_req, recycle;
	logic [7:0]                i_ctrl_wr_data;
	prot_resp_pkg::fault_vec_t i_fault_cond, i_flag_clear, o_fault_flags, o_trip_cause;
	prot_resp_pkg::ctrl_t      o_ctrl;
	logic [7:0]                q_ctrl[$];
	logic [2:0]                q_st[$];
	prot_resp_pkg::fault_vec_t q_cause[$];
	logic [2:0]                prev_st;
	wire logic [2:0]           st_now = {o_output_en, o_retrying, o_latched_off};
	int                        failures, tests_run, dummy;
	protection_response_config #(.RETRY_CYCLES(RC)) u_dut (
		.i_mclk, .i_rst_n, .i_ce, .i_ctrl_wr_en, .i_ctrl_wr_data, .i_flag_clear, .i_fault_cond,
		.i_ot_below_warn, .i_turn_on, .i_vin_ok, .o_ctrl, .o_fault_flags, .o_trip_cause,
		.o_output_en, .o_ramp_start, .o_retrying, .o_latched_off);
	host_model u_host (.i_mclk, .i_clr_req(clr_req), .i_recycle(recycle), .i_flags(o_fault_flags),
		.o_flag_clear(i_flag_clear), .o_turn_on(i_turn_on));
	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic chk_st(input logic [2:0] exp, input logic [2:0] got);
		chk({5'h00, exp}, {5'h00, got});
	endtask
	task wr(input logic [7:0] d);
		@(negedge i_mclk);
		i_ctrl_wr_en <= 1'h1;
		i_ctrl_wr_data <= d;
		q_ctrl.push_back(d);
		@(negedge i_mclk);
		i_ctrl_wr_en <= 1'h0;
	endtask
	task idle(input int n);
		@(negedge i_mclk);
		i_ctrl_wr_en <= 1'h0;
		repeat (n) @(negedge i_mclk);
	endtask
	task trip(input int b, input logic [2:0] st, input int n);
		@(negedge i_mclk);
		i_fault_cond[b] <= 1'h1;
		q_st.push_back(st);
		q_cause.push_back(prot_resp_pkg::fault_vec_t'(6'h01 << b));
		idle(n);
		chk(8'h00, {7'h00, o_fault_flags[b]});
		i_fault_cond[b] <= 1'h0;
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		i_mclk = 1'h0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	// results are taken at the falling edge, after the rising edge has settled them
	always @(negedge i_mclk) begin
		if (i_rst_n && i_ce && i_ctrl_wr_en)
			chk(q_ctrl.pop_front(), o_ctrl);
		if (i_rst_n && st_now != prev_st) begin
			chk_st(q_st.size() > 0 ? q_st.pop_front() : 3'h7, st_now);
			if (st_now == 3'h2 || st_now == 3'h1)
				chk({2'h0, q_cause.size() > 0 ? q_cause.pop_front() : 6'h3f}, {2'h0, o_trip_cause});
			if (st_now == 3'h4)
				chk(8'h01, {7'h00, o_ramp_start});
		end
		prev_st <= st_now;
	end
	initial begin
		repeat (5000) @(posedge i_mclk);
		failures++;
		report_and_stop();
	end
	initial begin
		dummy = $urandom(77058);
		{i_rst_n, i_ctrl_wr_en, i_ot_below_warn, clr_req, recycle, prev_st} = 8'h00;
		{i_ce, i_vin_ok, i_ctrl_wr_data, i_fault_cond} = 16'hc000;
		repeat (20) @(negedge i_mclk);
		chk(8'h43, o_ctrl);
		chk(8'h3f, {2'h0, o_fault_flags});
		q_st.push_back(3'h4);
		i_rst_n <= 1'h1;
		repeat (4) wr(8'($urandom));
		wr(8'h00);
		idle(2);
		i_fault_cond <= 6'h21;
		idle(5);
		i_fault_cond <= 6'h00;
		wr(8'hc0);
		trip(2, 3'h2, 30);
		q_st.push_back(3'h4);
		i_ce <= 1'h0;
		idle(5);
		i_ce <= 1'h1;
		idle(3 * RC);
		clr_req <= 1'h1;
		idle(1);
		clr_req <= 1'h0;
		for (int i = 0; i < 6; i++) begin
			wr(8'hc0 | (8'h01 << i));
			trip(i, 3'h1, 3);
			// early clear: the latch must still hold until the period has run out
			if (i == 1) begin
				clr_req <= 1'h1;
				idle(1);
				clr_req <= 1'h0;
				idle(RC / 2);
				chk_st(3'h1, st_now);
				q_st.push_back(3'h4);
			end
			idle(2 * RC);
			if (i > 3) begin
				recycle <= i[0];
				i_vin_ok <= i[0];
				q_st.push_back(3'h0);
				idle(2);
				recycle <= 1'h0;
				i_vin_ok <= 1'h1;
			end else if (i != 1) begin
				clr_req <= 1'h1;
				idle(1);
				clr_req <= 1'h0;
			end
			if (i != 1)
				q_st.push_back(3'h4);
			idle(RC);
		end
		wr(8'hc0);
		trip(4, 3'h2, 3);
		i_ot_below_warn <= 1'h1;
		q_st.push_back(3'h4);
		idle(6);
		chk(8'h00, 8'(q_st.size() + q_cause.size()));
		report_and_stop();
	end
endmodule
bind protection_response_config prot_resp_asserts #(.RETRY_CYCLES(RETRY_CYCLES)) u_chk (
	.i_mclk, .i_rst_n, .i_ce, .i_ctrl_wr_en, .i_ctrl_wr_data, .i_fault_cond, .i_ot_below_warn,
	.i_turn_on, .i_vin_ok, .o_ctrl, .o_fault_flags, .o_trip_cause, .o_output_en, .o_ramp_start,
	.o_retrying, .o_latched_off);
`default_nettype wire
